// [logic/mslm_limit_check.sv]
// Limit comparator: eight upper result bits against eight-bit high and low limits
`timescale 1ns/1ps
module mslm_limit_check
  import mslm_pkg::*;
(
  // Result and limits
  input wire logic [9:0] value,
  input wire logic [7:0] high_lim,
  input wire logic [7:0] low_lim,
  input wire logic signed_cmp,
  // Verdict
  output logic out_of_limit
);

  wire logic [7:0] value_msb;
  wire logic [7:0] value_key;
  wire logic [7:0] high_key;
  wire logic [7:0] low_key;

  // Limits are two bits narrower, so only the upper eight result bits take part [RULE14] [RULE22]
  assign value_msb = value[9:2];
  // Flipping the sign bit turns a signed compare into an unsigned one, so negative codes sort below zero [RULE12]
  assign value_key = {value_msb[7] ^ signed_cmp, value_msb[6:0]};
  assign high_key = {high_lim[7] ^ signed_cmp, high_lim[6:0]};
  assign low_key = {low_lim[7] ^ signed_cmp, low_lim[6:0]};
  // Above high, or at or below low [RULE13]
  assign out_of_limit = (value_key > high_key) || (value_key <= low_key);

endmodule : mslm_limit_check

// [logic/mslm_monitor.sv]
// Monitor sequencer: channel stepping, result formatting, limit flags and alarm output
//
// Notes on behaviour
// [RULE1] Reset: round robin selected, monitoring off
// [RULE2] Monitor enable bit starts conversions
// [RULE3] Round robin: supply, internal, external, repeat
// [RULE4] Single bit ends round robin, one channel
// [RULE5] Select zero: supply; low bit: internal
// [RULE6] Single mode conversions follow without gap
// [RULE7] Serial access aborts; conversions resume afterwards
// [RULE8] Supply: unsigned ten-bit code, prescaled input
// [RULE9] Internal offset added before storing result
// [RULE10] External result averages sixteen measurements
// [RULE11] Temperature step quarter degree, zero all zeros
// [RULE12] Negative code: drop sign, minus 512, quarter
// [RULE13] Out of limit: above high, at/below low
// [RULE14] Eight-bit limits against ten-bit results
// [RULE15] Unmasked out-of-limit results set status flags
// [RULE16] Any unmasked flag drives alarm, polarity selectable
// [RULE17] Host should mask unused channels
// [RULE18] Averaging on at reset; bit five disables
// [RULE19] Supply split: low bits and high byte
// [RULE20] Low-byte read freezes high bytes until read
// [RULE21] High select bit alone selects external
// [RULE22] Compare upper eight result bits with limit
`timescale 1ns/1ps
module mslm_monitor
  import mslm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial register port
  input wire logic host_busy,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Shared converter
  output logic conv_start,
  output logic conv_abort,
  output logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic [9:0] conv_raw,
  // Alarm pin
  output logic alarm
);

  mslm_state_t state_reg;
  mslm_state_t state_next;
  logic [7:0] config_one_reg;
  logic [7:0] control_two_reg;
  logic [7:0] mask_a_reg;
  logic [7:0] mask_b_reg;
  logic [7:0] int_offset_reg;
  logic [1:0] chan_reg;
  logic [1:0] chan_next;
  logic [3:0] count_reg;
  logic [13:0] acc_reg;
  logic [7:0] rdata_reg;
  logic start_reg;
  logic abort_reg;
  logic alarm_reg;
  logic lock_a_reg;
  logic lock_b_reg;
  logic [NUM_CH-1:0] fresh_reg;
  logic [NUM_CH-1:0] flag_reg;
  logic [9:0] result_reg [NUM_CH];
  logic [7:0] msb_reg [NUM_CH];
  logic [7:0] high_reg [NUM_CH];
  logic [7:0] low_reg [NUM_CH];

  // Control fields
  wire logic mon_en = config_one_reg[CFG_MON_EN_BIT];
  wire logic active_high = config_one_reg[CFG_POLARITY_BIT];
  wire logic single_mode = control_two_reg[CTL_SINGLE_BIT];
  wire logic avg_en = !control_two_reg[CTL_AVG_DIS_BIT];
  wire logic low_order_control_bit = control_two_reg[CTL_LOW_ORDER_BIT];
  wire logic channel_select_high = control_two_reg[CTL_SEL_HIGH_BIT];
  wire logic [NUM_CH-1:0] mask_vec = {mask_a_reg[1:0], mask_b_reg[0]};

  // Converter runs only while enabled and no serial access is under way [RULE2] [RULE7]
  wire logic run = mon_en && !host_busy;

  // Low select bit wins, then high bit, else supply [RULE5] [RULE21]
  wire logic [1:0] sel_chan = low_order_control_bit ? CH_INT : (channel_select_high ? CH_EXT : CH_SUPPLY);

  // Temperature channels average unless disabled; supply is always a single sample [RULE10] [RULE18]
  wire logic avg_active = avg_en && (chan_reg != CH_SUPPLY);
  wire logic sample_in = (state_reg == ST_WAIT) && conv_done && run;
  wire logic store = sample_in && (!avg_active || (count_reg == AVG_LAST));
  wire logic [13:0] raw_ext = {{4{conv_raw[9]}}, conv_raw};
  wire logic [13:0] acc_sum = acc_reg + raw_ext;
  // Arithmetic shift of the sum keeps two's complement and the quarter-degree step [RULE10] [RULE11]
  wire logic [9:0] temp_val = avg_active ? acc_sum[AVG_SHIFT+9:AVG_SHIFT] : conv_raw;
  // Offset is a signed count of result steps, added before storing; wraps on overflow [RULE9]
  wire logic [9:0] int_val = temp_val + {{2{int_offset_reg[7]}}, int_offset_reg};
  // Supply code passes through unsigned; prescaling is analog [RULE8]
  wire logic [9:0] new_val = (chan_reg == CH_INT) ? int_val : temp_val;

  // Next channel: fixed order in round robin, the selected one in single mode [RULE3] [RULE4]
  wire logic [1:0] rr_next = (chan_reg == CH_EXT) ? CH_SUPPLY : chan_reg + 2'h1;
  wire logic [1:0] chan_pick = single_mode ? sel_chan : rr_next;

  // Register port decode
  wire logic rd_status_a = reg_rd && (reg_addr == ADDR_STATUS_A);
  wire logic rd_status_b = reg_rd && (reg_addr == ADDR_STATUS_B);
  wire logic rd_lsb_a = reg_rd && (reg_addr == ADDR_LSB_SUP_INT);
  wire logic rd_lsb_b = reg_rd && (reg_addr == ADDR_LSB_EXT);
  wire logic rd_msb_a = reg_rd && ((reg_addr == ADDR_MSB_SUP) || (reg_addr == ADDR_MSB_INT));
  wire logic rd_msb_b = reg_rd && (reg_addr == ADDR_MSB_EXT);
  wire logic [NUM_CH-1:0] clr_vec = {rd_status_a, rd_status_a, rd_status_b};
  wire logic any_flag = |(flag_reg & ~mask_vec);

  // Sequencer state and channel choice
  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run) begin
          state_next = ST_START;
          // Round robin resumes on the channel that was cut off
          chan_next = single_mode ? sel_chan : chan_reg;
        end
      end
      ST_START: begin
        state_next = run ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (!run) begin
          state_next = ST_IDLE; // [RULE7]
        end else if (store) begin
          // Next conversion is launched at once, no idle cycle [RULE3] [RULE6]
          state_next = ST_START;
          chan_next = chan_pick;
        end else if (conv_done) begin
          state_next = ST_START;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      chan_reg <= CH_SUPPLY;
      start_reg <= 1'h0;
      abort_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      start_reg <= (state_reg == ST_START) && run;
      abort_reg <= (state_reg == ST_WAIT) && !run; // [RULE7]
    end
  end

  // Averaging accumulator; an abort throws away the partial sum
  always_ff @(posedge clock) begin
    if (rst || !run || store) begin
      acc_reg <= 14'h0000;
      count_reg <= 4'h0;
    end else if (sample_in) begin
      acc_reg <= acc_sum;
      count_reg <= count_reg + 4'h1;
    end
  end

  // Configuration registers; power-up leaves round robin selected and monitoring off [RULE1]
  always_ff @(posedge clock) begin
    if (rst) begin
      config_one_reg <= CONFIG_ONE_RESET;
      control_two_reg <= CONTROL_TWO_RESET; // [RULE18]
      mask_a_reg <= MASK_RESET;
      mask_b_reg <= MASK_RESET;
      int_offset_reg <= INT_OFFSET_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CONFIG_ONE) config_one_reg <= reg_wdata; // [RULE2]
      if (reg_addr == ADDR_CONTROL_TWO) control_two_reg <= reg_wdata; // [RULE4]
      if (reg_addr == ADDR_MASK_A) mask_a_reg <= reg_wdata;
      if (reg_addr == ADDR_MASK_B) mask_b_reg <= reg_wdata;
      if (reg_addr == ADDR_INT_OFFSET) int_offset_reg <= reg_wdata;
    end
  end

  // A low-byte read locks its high bytes; a read of one of them unlocks the group [RULE20]
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_a_reg <= 1'h0;
      lock_b_reg <= 1'h0;
    end else begin
      if (rd_msb_a) lock_a_reg <= 1'h0;
      else if (rd_lsb_a) lock_a_reg <= 1'h1;
      if (rd_msb_b) lock_b_reg <= 1'h0;
      else if (rd_lsb_b) lock_b_reg <= 1'h1;
    end
  end

  // Per-channel result, high byte, limits and status flag
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire logic out_lim;
    wire logic locked = (i == int'(CH_EXT)) ? lock_b_reg : lock_a_reg;
    wire logic [7:0] lim_addr = ADDR_LIMIT_BASE + 8'(2 * i);

    mslm_limit_check u_check (
      .value(result_reg[i]),
      .high_lim(high_reg[i]),
      .low_lim(low_reg[i]),
      .signed_cmp(i != int'(CH_SUPPLY)),
      .out_of_limit(out_lim)
    );

    always_ff @(posedge clock) begin
      if (rst) begin
        result_reg[i] <= RESULT_RESET;
        msb_reg[i] <= RESULT_RESET[9:2];
        fresh_reg[i] <= 1'h0;
        flag_reg[i] <= 1'h0;
        high_reg[i] <= (i == int'(CH_SUPPLY)) ? SUP_HIGH_RESET : TEMP_HIGH_RESET;
        low_reg[i] <= (i == int'(CH_SUPPLY)) ? SUP_LOW_RESET : TEMP_LOW_RESET;
      end else begin
        if (store && (chan_reg == 2'(i))) result_reg[i] <= new_val;
        // High byte tracks the result except while locked [RULE19] [RULE20]
        if (!locked) msb_reg[i] <= result_reg[i][9:2];
        fresh_reg[i] <= store && (chan_reg == 2'(i));
        // A new unmasked violation wins over a clear-on-read in the same cycle [RULE15]
        if (fresh_reg[i] && out_lim && !mask_vec[i]) flag_reg[i] <= 1'h1;
        else if (clr_vec[i]) flag_reg[i] <= 1'h0;
        if (reg_wr && (reg_addr == lim_addr)) high_reg[i] <= reg_wdata;
        if (reg_wr && (reg_addr == lim_addr + 8'h01)) low_reg[i] <= reg_wdata;
      end
    end
  end

  // Read data: supply low bits share a register with internal low bits [RULE19]
  wire logic [7:0] lsb_a_val = {4'h0, result_reg[CH_INT][1:0], result_reg[CH_SUPPLY][1:0]};
  wire logic [7:0] rd_mux =
    (reg_addr == ADDR_STATUS_A) ? {6'h00, flag_reg[2:1]} :
    (reg_addr == ADDR_STATUS_B) ? {7'h00, flag_reg[0]} :
    (reg_addr == ADDR_LSB_SUP_INT) ? lsb_a_val :
    (reg_addr == ADDR_LSB_EXT) ? {6'h00, result_reg[CH_EXT][1:0]} :
    (reg_addr == ADDR_MSB_SUP) ? msb_reg[CH_SUPPLY] :
    (reg_addr == ADDR_MSB_INT) ? msb_reg[CH_INT] :
    (reg_addr == ADDR_MSB_EXT) ? msb_reg[CH_EXT] :
    (reg_addr == ADDR_CONFIG_ONE) ? config_one_reg :
    (reg_addr == ADDR_CONTROL_TWO) ? control_two_reg :
    (reg_addr == ADDR_MASK_A) ? mask_a_reg :
    (reg_addr == ADDR_MASK_B) ? mask_b_reg :
    (reg_addr == ADDR_INT_OFFSET) ? int_offset_reg :
    (reg_addr == ADDR_LIMIT_BASE) ? high_reg[0] :
    (reg_addr == ADDR_LIMIT_BASE + 8'h01) ? low_reg[0] :
    (reg_addr == ADDR_LIMIT_BASE + 8'h02) ? high_reg[1] :
    (reg_addr == ADDR_LIMIT_BASE + 8'h03) ? low_reg[1] :
    (reg_addr == ADDR_LIMIT_BASE + 8'h04) ? high_reg[2] :
    (reg_addr == ADDR_LIMIT_BASE + 8'h05) ? low_reg[2] : 8'h00;

  // Read data and alarm pin; alarm level follows the polarity bit [RULE16]
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      alarm_reg <= ALARM_RESET;
    end else begin
      if (reg_rd) rdata_reg <= rd_mux;
      alarm_reg <= active_high ? any_flag : !any_flag;
    end
  end

  assign reg_rdata = rdata_reg;
  assign conv_start = start_reg;
  assign conv_abort = abort_reg;
  assign conv_channel = chan_reg;
  assign alarm = alarm_reg;

  // Checks
  a_quiet_when_off: assert property (@(posedge clock) disable iff (rst) // [RULE1]
    !mon_en ##1 !mon_en |-> ##1 !conv_start) else $error("conversion started while monitoring off");

  a_stop_on_access: assert property (@(posedge clock) disable iff (rst) // [RULE7]
    host_busy |=> !conv_start) else $error("conversion started during serial access");

  a_abort_in_flight: assert property (@(posedge clock) disable iff (rst) // [RULE7]
    (state_reg == ST_WAIT) && mon_en && host_busy |=> conv_abort) else $error("missing abort");

  a_rr_order: assert property (@(posedge clock) disable iff (rst) // [RULE3]
    store && !single_mode |=> conv_channel == (($past(chan_reg) == CH_EXT) ? CH_SUPPLY : $past(chan_reg) + 2'h1))
    else $error("round robin order broken");

  a_single_select: assert property (@(posedge clock) disable iff (rst) // [RULE5]
    store && single_mode && $stable(control_two_reg) |=> conv_channel == sel_chan) else $error("wrong single channel");

  a_no_gap: assert property (@(posedge clock) disable iff (rst) // [RULE6]
    store ##1 run[*2] |-> conv_start) else $error("gap between conversions");

  // Starts since the last stored result, counted apart from the sample counter so a wrong count shows
  logic [4:0] starts_seen_reg;
  always_ff @(posedge clock) begin
    if (rst || !run || store) begin
      starts_seen_reg <= 5'h00;
    end else if (conv_start) begin
      starts_seen_reg <= starts_seen_reg + 5'h01;
    end
  end

  a_avg_sixteen: assert property (@(posedge clock) disable iff (rst) // [RULE10]
    store && avg_active |-> starts_seen_reg == 5'(AVG_LAST) + 5'h01) else $error("average not over sixteen samples");

  a_avg_single: assert property (@(posedge clock) disable iff (rst) // [RULE18]
    store && !avg_active |-> starts_seen_reg == 5'h01) else $error("single-sample result not after one start");

  a_supply_raw: assert property (@(posedge clock) disable iff (rst) // [RULE8]
    store && (chan_reg == CH_SUPPLY) |=> result_reg[0] == $past(conv_raw)) else $error("supply code altered");

  a_flag_sets: assert property (@(posedge clock) disable iff (rst) // [RULE15]
    store && (chan_reg == CH_EXT) && !mask_vec[2] && !reg_wr &&
    (($signed(new_val[9:2]) > $signed(high_reg[2])) || ($signed(new_val[9:2]) <= $signed(low_reg[2])))
    |-> ##2 flag_reg[2]) else $error("external flag not set");

  a_mask_quiet: assert property (@(posedge clock) disable iff (rst) // [RULE15]
    mask_vec[0] && !flag_reg[0] |=> !flag_reg[0]) else $error("masked supply flag set");

  a_alarm_follows: assert property (@(posedge clock) disable iff (rst) // [RULE16]
    (any_flag && active_high)[*2] |-> alarm) else $error("alarm not active");

  a_alarm_low: assert property (@(posedge clock) disable iff (rst) // [RULE16]
    (any_flag && !active_high)[*2] |-> !alarm) else $error("low-active alarm not driven low");

  a_lock_hold: assert property (@(posedge clock) disable iff (rst) // [RULE20]
    lock_a_reg |=> $stable(msb_reg[0])) else $error("locked high byte changed");

  a_lock_b_hold: assert property (@(posedge clock) disable iff (rst) // [RULE20]
    lock_b_reg |=> $stable(msb_reg[2])) else $error("locked external high byte changed");

  c_ext_store: cover property (@(posedge clock) disable iff (rst) store && chan_reg == CH_EXT);
  c_single_run: cover property (@(posedge clock) disable iff (rst) conv_start && single_mode);
  c_abort: cover property (@(posedge clock) disable iff (rst) conv_abort);
  c_lock: cover property (@(posedge clock) disable iff (rst) lock_a_reg && store);
  c_avg_off: cover property (@(posedge clock) disable iff (rst) store && !avg_en && chan_reg == CH_EXT);

endmodule : mslm_monitor

// [logic/mslm_pkg.sv]
// Package: register map, field positions, reset values and channel codes of the monitor sequencer
package mslm_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_STATUS_A = 8'h00;
  localparam logic [7:0] ADDR_STATUS_B = 8'h01;
  localparam logic [7:0] ADDR_LSB_SUP_INT = 8'h03;
  localparam logic [7:0] ADDR_LSB_EXT = 8'h04;
  localparam logic [7:0] ADDR_MSB_SUP = 8'h06;
  localparam logic [7:0] ADDR_MSB_INT = 8'h07;
  localparam logic [7:0] ADDR_MSB_EXT = 8'h08;
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h18;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h19;
  localparam logic [7:0] ADDR_MASK_A = 8'h1C;
  localparam logic [7:0] ADDR_MASK_B = 8'h1D;
  localparam logic [7:0] ADDR_INT_OFFSET = 8'h1E;
  // Limits: high at LIMIT_BASE + 2*channel, low one above it
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h23;

  // Field positions
  localparam int CFG_MON_EN_BIT = 0;
  localparam int CFG_POLARITY_BIT = 1;
  localparam int CTL_LOW_ORDER_BIT = 0;
  localparam int CTL_SEL_HIGH_BIT = 1;
  localparam int CTL_SINGLE_BIT = 4;
  localparam int CTL_AVG_DIS_BIT = 5;
  localparam int LSB_INT_POS = 2;

  // Reset values
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] INT_OFFSET_RESET = 8'h00;
  localparam logic [7:0] SUP_HIGH_RESET = 8'hFF;
  localparam logic [7:0] SUP_LOW_RESET = 8'h00;
  localparam logic [7:0] TEMP_HIGH_RESET = 8'h7F;
  localparam logic [7:0] TEMP_LOW_RESET = 8'h80;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic ALARM_RESET = 1'h1;

  // Channels of the shared converter
  localparam int NUM_CH = 3;
  localparam logic [1:0] CH_SUPPLY = 2'h0;
  localparam logic [1:0] CH_INT = 2'h1;
  localparam logic [1:0] CH_EXT = 2'h2;

  // Averaging: sixteen samples, sum carries four guard bits
  localparam logic [3:0] AVG_LAST = 4'hF;
  localparam int AVG_SHIFT = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} mslm_state_t;

endpackage : mslm_pkg

// [tb/mslm_conv_model.sv]
// Converter stand-in: answers each start after a fixed delay, drops work on abort
`timescale 1ns/1ps
module mslm_conv_model
  import mslm_pkg::*;
#(
  parameter int LAT = 5
)(
  // Clock
  input wire logic clock,
  // Requests from the sequencer
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [1:0] conv_channel,
  // Answer
  output logic conv_done,
  output logic [9:0] conv_raw,
  // Raw codes per channel, set by the bench
  input wire logic [9:0] raw_sup,
  input wire logic [9:0] raw_int,
  input wire logic [9:0] raw_ext
);
  int cnt = 0;
  logic [9:0] junk = 10'h155;
  initial begin
    conv_done = 1'b0;
    conv_raw = 10'h155;
  end
  // Raw bus toggles outside done so a stale code is never mistaken for a result
  always @(posedge clock) begin
    #1;
    conv_done = 1'b0;
    junk = ~junk;
    conv_raw = junk;
    if (conv_abort === 1'b1) begin
      cnt = 0;
    end else if (conv_start === 1'b1) begin
      cnt = LAT;
    end else if (cnt == 1) begin
      cnt = 0;
      conv_done = 1'b1;
      conv_raw = (conv_channel == CH_SUPPLY) ? raw_sup : (conv_channel == CH_INT) ? raw_int : raw_ext;
    end else if (cnt > 1) begin
      cnt = cnt - 1;
    end
  end
endmodule : mslm_conv_model

// [tb/tb_top.sv]
// Self-checking bench for the monitor sequencer against a converter stand-in
`timescale 1ns/1ps
module tb_top
  import mslm_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, host_busy = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic conv_start, conv_abort, conv_done, alarm;
  logic [1:0] conv_channel, ch;
  logic [9:0] conv_raw, raw_sup = 10'h2DB, raw_int = 10'h3FF, raw_ext = 10'h190;
  logic [1:0] chq[$];
  int n_fail = 0, tests_run = 0;
  bit ok;
  mslm_monitor u_dut (.clock(clock), .rst(rst), .host_busy(host_busy), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel), .conv_done(conv_done), .conv_raw(conv_raw),
    .alarm(alarm));
  mslm_conv_model u_conv (.clock(clock), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_raw(conv_raw), .raw_sup(raw_sup),
    .raw_int(raw_int), .raw_ext(raw_ext));
  always #25 clock = ~clock;
  // Log the channel of every start; values read here are those of the cycle just ended
  always @(posedge clock) if (conv_start === 1'b1) chq.push_back(conv_channel);
  task report_and_stop;
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [9:0] ex, input logic [9:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // Serial access: busy framed around a one-cycle strobe, one idle edge before the next access
  task wr(input logic [7:0] a, input logic [7:0] d);
    host_busy = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
    host_busy = 1'b0;
    step(1);
  endtask : wr
  task rd(input logic [7:0] a);
    host_busy = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    step(1);
    v = reg_rdata;
    host_busy = 1'b0;
    step(1);
  endtask : rd
  task wait_start;
    int i;
    ok = 1'b0;
    for (i = 0; i < 40 && !ok; i++) begin
      step(1);
      if (conv_start === 1'b1) ok = 1'b1;
    end
  endtask : wait_start
  task chk_all(input logic [1:0] c);
    chk("start count", 1'b1, chq.size() > 4);
    foreach (chq[i]) chk("channel", c, chq[i]);
  endtask : chk_all
  task t_reset;
    step(40);
    chk("idle starts", 0, chq.size());
    chk("alarm idle", 1, alarm);
    rd(ADDR_CONFIG_ONE); chk("config_one", 8'h00, v);
    rd(ADDR_CONTROL_TWO); chk("control_two", 8'h00, v);
    rd(8'h02); chk("unmapped", 8'h00, v);
  endtask : t_reset
  task t_round;
    wr(ADDR_CONFIG_ONE, 8'h01);
    step(400);
    chk("start count", 1'b1, chq.size() >= 34);
    chk("first ch", CH_SUPPLY, chq[0]);
    chk("int begins", CH_INT, chq[1]);
    chk("int 16th", CH_INT, chq[16]);
    chk("ext begins", CH_EXT, chq[17]);
    chk("ext 16th", CH_EXT, chq[32]);
    chk("wraps", CH_SUPPLY, chq[33]);
    rd(ADDR_LSB_SUP_INT); chk("low bits", 8'h0F, v & 8'h0F);
    raw_sup = 10'h3FF;
    step(300);
    rd(ADDR_MSB_SUP); chk("supply msb", 8'hB6, v);
    rd(ADDR_MSB_INT); chk("int msb", 8'hFF, v);
    rd(ADDR_LSB_EXT); chk("ext low", 8'h00, v & 8'h03);
    rd(ADDR_MSB_EXT); chk("ext msb", 8'h64, v);
    step(300);
    rd(ADDR_MSB_SUP); chk("unlocked msb", 8'hFF, v);
  endtask : t_round
  task t_abort;
    wait_start;
    ch = conv_channel;
    host_busy = 1'b1;
    step(1); chk("abort", 1, conv_abort);
    chq.delete();
    step(10); chk("busy starts", 0, chq.size());
    host_busy = 1'b0;
    wait_start; chk("resume", 1, ok);
    chk("resume ch", ch, conv_channel);
  endtask : t_abort
  task t_limit;
    rd(ADDR_STATUS_B);
    step(300);
    rd(ADDR_STATUS_B); chk("at high", 8'h00, v);
    wr(ADDR_LIMIT_BASE, 8'hFE);
    step(300);
    chk("alarm low", 0, alarm);
    rd(ADDR_STATUS_B); chk("above high", 8'h01, v);
    wr(ADDR_CONFIG_ONE, 8'h03);
    step(300); chk("alarm high", 1, alarm);
    // Supply channel is no longer of interest here, so it is masked
    wr(ADDR_MASK_B, 8'h01);
    rd(ADDR_STATUS_B);
    step(300);
    rd(ADDR_STATUS_B); chk("masked", 8'h00, v);
    chk("alarm off", 0, alarm);
  endtask : t_limit
  task t_single;
    int i;
    wr(ADDR_CONTROL_TWO, 8'h10);
    step(20); chq.delete(); step(100);
    chk_all(CH_SUPPLY);
    for (i = 0; i < 20 && conv_done !== 1'b1; i++) step(1);
    step(1); chk("gap", 0, conv_start);
    step(1); chk("no gap", 1, conv_start);
    wr(ADDR_INT_OFFSET, 8'h04);
    wr(ADDR_CONTROL_TWO, 8'h11);
    step(20); chq.delete(); step(250);
    chk_all(CH_INT);
    rd(ADDR_MSB_INT); chk("offset msb", 8'h00, v);
    rd(ADDR_LSB_SUP_INT); chk("offset low", 8'h0C, v & 8'h0C);
    wr(ADDR_CONTROL_TWO, 8'h12);
    step(20); chq.delete(); step(100);
    chk_all(CH_EXT);
    // Averaging off: one conversion per result, far sooner than sixteen would take
    wr(ADDR_CONTROL_TWO, 8'h32);
    raw_ext = 10'h3F0;
    wr(ADDR_LIMIT_BASE + 8'h04, 8'h10);
    rd(ADDR_STATUS_A);
    step(30);
    rd(ADDR_MSB_EXT); chk("unaveraged msb", 8'hFC, v);
    rd(ADDR_STATUS_A); chk("signed high", 8'h00, v);
    wr(ADDR_LIMIT_BASE + 8'h05, 8'hFC);
    step(30);
    chk("alarm ext", 1, alarm);
    rd(ADDR_STATUS_A); chk("at low", 8'h02, v);
  endtask : t_single
  initial begin
    #(20000 * 50);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clock);
    #2 rst = 1'b0;
    t_reset;
    t_round;
    t_abort;
    t_limit;
    t_single;
    report_and_stop;
  end
endmodule : tb_top
